//--- rtl/sensor_cmd_pkg.sv
// Constants shared by the sensor command and alert logic
package sensor_cmd_pkg;

  // ==========================================================
  // Command codes (register index values)
  localparam logic [7:0] CMD_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] CMD_CFG_RD = 8'h03;
  localparam logic [7:0] CMD_RATE_RD = 8'h04;
  localparam logic [7:0] CMD_LHI_RD = 8'h05;
  localparam logic [7:0] CMD_LLO_RD = 8'h06;
  localparam logic [7:0] CMD_RHI_RD = 8'h07;
  localparam logic [7:0] CMD_RLO_RD = 8'h08;
  localparam logic [7:0] CMD_CFG_WR = 8'h09;
  localparam logic [7:0] CMD_RATE_WR = 8'h0A;
  localparam logic [7:0] CMD_LHI_WR = 8'h0B;
  localparam logic [7:0] CMD_LLO_WR = 8'h0C;
  localparam logic [7:0] CMD_RHI_WR = 8'h0D;
  localparam logic [7:0] CMD_RLO_WR = 8'h0E;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
  localparam logic [7:0] CMD_REMOTE_FRAC = 8'h10;
  localparam logic [7:0] CMD_LOCAL_FRAC = 8'h11;
  localparam logic [7:0] CMD_PART_ID = 8'hFE;
  localparam logic [7:0] CMD_PART_REV = 8'hFF;

  // ==========================================================
  // Reset values and fixed answers
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] HI_LIMIT_RST = 8'h7F;
  localparam logic [7:0] LO_LIMIT_RST = 8'hC9;
  localparam logic [7:0] UNDEF_READ = 8'h00;
  localparam logic [7:0] TEMP_UNDER = 8'h80;
  // Identity codes: values are arbitrary
  localparam logic [7:0] PART_ID_VAL = 8'h5A;
  localparam logic [7:0] PART_REV_VAL = 8'h01;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // ==========================================================
  // Configuration and status bit positions
  localparam int IRQ_MASK_BIT = 7;
  localparam int STANDBY_BIT = 6;
  localparam int EXT_RANGE_BIT = 5;
  localparam int SERIES_RES_BIT = 4;
  localparam int CPU_JUNCTION_BIT = 3;
  localparam int BUSY_BIT = 7;
  localparam logic [7:0] CFG_WR_MASK = 8'hF8;
  localparam logic [2:0] RATE_1HZ = 3'h4;
  localparam logic [2:0] RATE_FASTEST = 3'h7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FAST_INTERVAL_MS = 125;
  localparam int FAST_INTERVAL_CYC =
    FAST_INTERVAL_MS * (1000000 / CLK_PERIOD_NS);
  localparam int STRAP_WAIT = 3;

  // ==========================================================
  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101
  } slave_state_e;

endpackage

//--- rtl/sensor_command_alert_logic.sv
// Serial register bank, conversion control and latched alert of the sensor
// How it works
// RULE1: Alert response reply is latched slave address in bits 7-1, bit 0 one.
// RULE2: Alert latches; released by status read or alert reply once cause gone.
// RULE3: Alert raised on limit trips of either channel and on open diode.
// RULE4: Active alert never stops conversions; results keep updating.
// RULE5: Alert pin only pulls low or releases.
// RULE6: Alert events arise only at conversion end, once per conversion.
// RULE7: Host reads alert response address; pending slaves answer with address.
// RULE8: Arbitration loser stops driving, gives no ack, keeps alert low.
// RULE9: Alert released after full address reply if cause has ended.
// RULE10: Register index resets to zero, so bare reads give local temperature.
// RULE11: One-shot in standby runs one conversion, then stays in standby.
// RULE12: One-shot during a running conversion is ignored.
// RULE13: One-shot in autoconvert restarts the rate timer for a full interval.
// RULE14: Configuration bit 7 set suppresses the alert output; resets zero.
// RULE15: Configuration bit 6 set means standby, clear means autoconvert.
// RULE16: Configuration bit 5 extends the low temperature range to minus 64.
// RULE17: Bit 4 enables series cancellation only at 1 Hz or slower rates.
// RULE18: Host should set bit 3 for a processor junction; resets zero.
// RULE19: Status read clears flags except persisting ones; flags reset zero.
// RULE20: Clearing flags alone never releases the alert while cause persists.
// RULE21: Host reads status no sooner than conversion end, at most 150 ms.
// RULE22: Command byte indexes registers; reads and writes use distinct codes.
// RULE23: Status bit 7 busy, bits 6-3 limit alarms, bit 2 open diode.
// RULE24: Address strap sampled once after reset and held.
// RULE25: Undefined write codes ignored; undefined reads return a fixed value.
module sensor_command_alert_logic #(
  parameter int unsigned FAST_CYCLES = sensor_cmd_pkg::FAST_INTERVAL_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic SMB_SCL,
  input wire logic SMB_SDA_IN,
  output logic SMB_SDA_OUT,
  output logic SMB_SDA_OE,
  output logic ALERT_OUT,
  output logic ALERT_OE,
  input wire logic [6:0] ADDR_STRAP,
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [7:0] LOCAL_TEMP_IN,
  input wire logic [7:0] REMOTE_TEMP_IN,
  input wire logic [7:0] LOCAL_FRAC_IN,
  input wire logic [7:0] REMOTE_FRAC_IN,
  input wire logic DIODE_OPEN_IN,
  output logic EXT_RANGE,
  output logic SERIES_CANCEL,
  output logic CPU_JUNCTION
);

  // ==========================================================
  // Elaboration check
  // Interval is FAST_CYCLES shifted left by up to 7 in a 32-bit timer
  if (FAST_CYCLES < 1 || FAST_CYCLES > 32'h01FFFFFF) begin : g_chk
    $error("FAST_CYCLES out of range");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    sensor_cmd_pkg::slave_state_e state;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic is_ara;
    logic byte_no;
    logic ack_on;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] ltemp;
    logic [7:0] rtemp;
    logic [7:0] lfrac;
    logic [7:0] rfrac;
    logic [4:0] flags;
    logic [4:0] cond;
    logic alert;
    logic alert_oe;
    logic busy;
    logic start;
    logic first;
    logic [31:0] timer;
    logic [6:0] strap_s1;
    logic [6:0] strap_s2;
    logic [6:0] my_addr;
    logic [1:0] strap_cnt;
    logic ara_done;
    logic stat_read;
    logic ext_o;
    logic prc_o;
    logic cpu_o;
  } state_s;

  state_s r;
  state_s n;

  // Read mux over the command index
  function automatic logic [7:0] read_reg(input state_s s);
    logic [7:0] v;
    v = sensor_cmd_pkg::UNDEF_READ; // RULE25
    if (s.ptr == sensor_cmd_pkg::CMD_LOCAL_TEMP) v = s.ltemp; // RULE22
    else if (s.ptr == sensor_cmd_pkg::CMD_REMOTE_TEMP) v = s.rtemp;
    else if (s.ptr == sensor_cmd_pkg::CMD_STATUS)
      v = {s.busy, s.flags, 2'b00}; // RULE23
    else if (s.ptr == sensor_cmd_pkg::CMD_CFG_RD) v = s.cfg;
    else if (s.ptr == sensor_cmd_pkg::CMD_RATE_RD) v = s.rate;
    else if (s.ptr == sensor_cmd_pkg::CMD_LHI_RD) v = s.lhi;
    else if (s.ptr == sensor_cmd_pkg::CMD_LLO_RD) v = s.llo;
    else if (s.ptr == sensor_cmd_pkg::CMD_RHI_RD) v = s.rhi;
    else if (s.ptr == sensor_cmd_pkg::CMD_RLO_RD) v = s.rlo;
    else if (s.ptr == sensor_cmd_pkg::CMD_REMOTE_FRAC) v = s.rfrac;
    else if (s.ptr == sensor_cmd_pkg::CMD_LOCAL_FRAC) v = s.lfrac;
    else if (s.ptr == sensor_cmd_pkg::CMD_PART_ID)
      v = sensor_cmd_pkg::PART_ID_VAL;
    else if (s.ptr == sensor_cmd_pkg::CMD_PART_REV)
      v = sensor_cmd_pkg::PART_REV_VAL;
    return v;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] in_byte;
    logic one_shot;
    logic start_now;
    logic [7:0] lt;
    logic [7:0] rt;
    logic [4:0] new_cond;
    logic [31:0] interval;
    logic [7:0] tx;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    in_byte = 8'h00;
    one_shot = 1'b0;
    start_now = 1'b0;
    lt = 8'h00;
    rt = 8'h00;
    new_cond = 5'h00;
    interval = 32'h0;
    tx = 8'h00;
    n = r;
    n.ara_done = 1'b0;
    n.stat_read = 1'b0;
    n.start = 1'b0;

    // Pin synchronisers; only the second stage and its delayed copy feed logic
    n.scl_s1 = SMB_SCL;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = SMB_SDA_IN;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    scl_rise = r.scl_s2 && !r.scl_d;
    scl_fall = !r.scl_s2 && r.scl_d;
    start_c = r.scl_s2 && r.scl_d && !r.sda_s2 && r.sda_d;
    stop_c = r.scl_s2 && r.scl_d && r.sda_s2 && !r.sda_d;
    in_byte = {r.shreg[6:0], r.sda_s2};

    // Address strap capture, once after reset
    n.strap_s1 = ADDR_STRAP;
    n.strap_s2 = r.strap_s1;
    if (r.strap_cnt != 2'(sensor_cmd_pkg::STRAP_WAIT)) begin
      n.strap_cnt = r.strap_cnt + 2'd1;
      n.my_addr = r.strap_s2; // RULE24
    end

    // Serial slave
    if (start_c) begin
      n.state = sensor_cmd_pkg::ST_ADDR;
      n.bitcnt = 3'd0;
      n.sda_oe = 1'b0;
      n.byte_no = 1'b0;
    end else if (stop_c) begin
      n.state = sensor_cmd_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.state)
        sensor_cmd_pkg::ST_ADDR: begin
          if (scl_rise) begin
            n.shreg = in_byte;
            n.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == 3'd7) begin
              n.rw = r.sda_s2;
              n.ack_on = 1'b0;
              n.is_ara = 1'b0;
              if (in_byte[7:1] == r.my_addr) begin
                n.state = sensor_cmd_pkg::ST_ACK;
              end else if (in_byte[7:1] ==
                  sensor_cmd_pkg::ALERT_RESP_ADDR && r.sda_s2 &&
                  r.alert) begin
                n.state = sensor_cmd_pkg::ST_ACK; // RULE7
                n.is_ara = 1'b1;
              end else begin
                n.state = sensor_cmd_pkg::ST_IDLE;
              end
            end
          end
        end
        sensor_cmd_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (!r.ack_on) begin
              n.ack_on = 1'b1;
              n.sda_oe = 1'b1;
            end else if (r.rw) begin
              tx = r.is_ara ? {r.my_addr, 1'b1} : read_reg(r); // RULE1
              n.shreg = tx;
              n.sda_oe = !tx[7];
              n.bitcnt = 3'd0;
              n.state = sensor_cmd_pkg::ST_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.bitcnt = 3'd0;
              n.state = sensor_cmd_pkg::ST_RX;
            end
          end
        end
        sensor_cmd_pkg::ST_RX: begin
          if (scl_rise) begin
            n.shreg = in_byte;
            n.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == 3'd7) begin
              n.state = sensor_cmd_pkg::ST_ACK;
              n.ack_on = 1'b0;
              n.byte_no = 1'b1;
              if (!r.byte_no) begin
                n.ptr = in_byte; // RULE22
                one_shot = in_byte == sensor_cmd_pkg::CMD_ONE_SHOT;
              end else if (r.ptr == sensor_cmd_pkg::CMD_CFG_WR) begin
                n.cfg = in_byte & sensor_cmd_pkg::CFG_WR_MASK;
              end else if (r.ptr == sensor_cmd_pkg::CMD_RATE_WR) begin
                n.rate = in_byte;
              end else if (r.ptr == sensor_cmd_pkg::CMD_LHI_WR) begin
                n.lhi = in_byte;
              end else if (r.ptr == sensor_cmd_pkg::CMD_LLO_WR) begin
                n.llo = in_byte;
              end else if (r.ptr == sensor_cmd_pkg::CMD_RHI_WR) begin
                n.rhi = in_byte;
              end else if (r.ptr == sensor_cmd_pkg::CMD_RLO_WR) begin
                n.rlo = in_byte;
              end
            end
          end
        end
        sensor_cmd_pkg::ST_TX: begin
          if (scl_rise && !r.sda_oe && !r.sda_s2 &&
              r.shreg[7]) begin
            n.state = sensor_cmd_pkg::ST_IDLE; // RULE8
          end else if (scl_rise && r.bitcnt == 3'd7) begin
            n.state = sensor_cmd_pkg::ST_TXACK;
            n.ara_done = r.is_ara; // RULE9
            n.stat_read = !r.is_ara &&
              r.ptr == sensor_cmd_pkg::CMD_STATUS;
          end else if (scl_fall) begin
            n.bitcnt = r.bitcnt + 3'd1;
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_oe = !r.shreg[6];
          end
        end
        sensor_cmd_pkg::ST_TXACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
          end else if (scl_rise) begin
            n.ack_on = 1'b1;
            n.state = r.sda_s2 ? sensor_cmd_pkg::ST_IDLE :
              sensor_cmd_pkg::ST_ACK;
          end
        end
        default: begin
          n.state = sensor_cmd_pkg::ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Conversion scheduling
    interval = 32'(FAST_CYCLES) <<
      (sensor_cmd_pkg::RATE_FASTEST - r.rate[2:0]);
    if (r.first) begin
      start_now = 1'b1;
    end else if (one_shot && !r.busy) begin
      start_now = 1'b1; // RULE11 RULE12 RULE13
    end else if (!r.cfg[sensor_cmd_pkg::STANDBY_BIT] && !r.busy &&
        r.timer >= interval - 32'd1) begin
      start_now = 1'b1; // RULE15
    end
    if (start_now) begin
      n.first = 1'b0;
      n.busy = 1'b1;
      n.start = 1'b1;
      n.timer = 32'h0; // RULE13
    end else if (r.cfg[sensor_cmd_pkg::STANDBY_BIT]) begin
      n.timer = 32'h0;
    end else if (r.timer < interval) begin
      n.timer = r.timer + 32'd1;
    end
    if (CONV_DONE) begin
      n.busy = start_now;
    end

    // Result capture and limit comparison
    lt = (!r.cfg[sensor_cmd_pkg::EXT_RANGE_BIT] && LOCAL_TEMP_IN[7]) ?
      sensor_cmd_pkg::TEMP_UNDER : LOCAL_TEMP_IN; // RULE16
    rt = (DIODE_OPEN_IN || (!r.cfg[sensor_cmd_pkg::EXT_RANGE_BIT] &&
      REMOTE_TEMP_IN[7])) ? sensor_cmd_pkg::TEMP_UNDER : REMOTE_TEMP_IN;
    new_cond = {$signed(lt) >= $signed(r.lhi),
      $signed(lt) <= $signed(r.llo),
      $signed(rt) >= $signed(r.rhi),
      $signed(rt) <= $signed(r.rlo), DIODE_OPEN_IN}; // RULE3
    if (CONV_DONE) begin
      n.ltemp = lt; // RULE4
      n.rtemp = rt;
      n.lfrac = LOCAL_FRAC_IN;
      n.rfrac = REMOTE_FRAC_IN;
      n.cond = new_cond;
    end

    // Status flags: new events win over the read clear
    if (r.stat_read) begin
      n.flags = r.flags & r.cond; // RULE19
    end
    if (CONV_DONE) begin
      n.flags = n.flags | new_cond;
    end

    // Alert latch, set only at conversion end
    if (CONV_DONE && new_cond != 5'h00) begin
      n.alert = 1'b1; // RULE6
    end else if ((r.stat_read || r.ara_done) && r.cond == 5'h00) begin
      n.alert = 1'b0; // RULE2 RULE20
    end
    n.alert_oe = n.alert && !n.cfg[sensor_cmd_pkg::IRQ_MASK_BIT]; // RULE14

    // Mode outputs
    n.ext_o = n.cfg[sensor_cmd_pkg::EXT_RANGE_BIT];
    n.prc_o = n.cfg[sensor_cmd_pkg::SERIES_RES_BIT] &&
      n.rate[2:0] <= sensor_cmd_pkg::RATE_1HZ; // RULE17
    n.cpu_o = n.cfg[sensor_cmd_pkg::CPU_JUNCTION_BIT]; // RULE18
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d <= 1'b1;
      r.ptr <= sensor_cmd_pkg::INDEX_RST; // RULE10
      r.rate <= sensor_cmd_pkg::RATE_RST;
      r.lhi <= sensor_cmd_pkg::HI_LIMIT_RST;
      r.rhi <= sensor_cmd_pkg::HI_LIMIT_RST;
      r.llo <= sensor_cmd_pkg::LO_LIMIT_RST;
      r.rlo <= sensor_cmd_pkg::LO_LIMIT_RST;
      r.first <= 1'b1;
    end else if (CLK_EN) begin
      r <= n;
    end
  end

  // Pin drivers: only ever pull low
  assign SMB_SDA_OUT = 1'b0;
  assign ALERT_OUT = 1'b0; // RULE5
  assign SMB_SDA_OE = r.sda_oe;
  assign ALERT_OE = r.alert_oe;
  assign CONV_START = r.start;
  assign EXT_RANGE = r.ext_o;
  assign SERIES_CANCEL = r.prc_o;
  assign CPU_JUNCTION = r.cpu_o;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  ara_reply_a: assert property ( // RULE1
    CLK_EN && r.state == sensor_cmd_pkg::ST_ACK && r.is_ara &&
    r.rw && r.ack_on && !r.scl_s2 && r.scl_d
    |=> r.shreg == {r.my_addr, 1'b1})
    else $error("alert reply byte wrong");
  alert_hold_a: assert property ( // RULE2
    r.alert && r.cond != 5'h00 |=> r.alert)
    else $error("alert released while cause persists");
  alert_set_a: assert property ( // RULE3
    CLK_EN && CONV_DONE && DIODE_OPEN_IN |=> r.alert && r.flags[0])
    else $error("open diode did not raise alert");
  temp_update_a: assert property ( // RULE4
    CLK_EN && CONV_DONE && !LOCAL_TEMP_IN[7]
    |=> r.ltemp == $past(LOCAL_TEMP_IN))
    else $error("local result not captured");
  pin_low_a: assert property ( // RULE5
    ALERT_OUT == 1'b0 && (!ALERT_OE || r.alert))
    else $error("alert pin driven high or without cause");
  alert_rate_a: assert property ( // RULE6
    $rose(r.alert) |-> $past(CONV_DONE))
    else $error("alert rose outside conversion end");
  ara_clear_a: assert property ( // RULE9
    CLK_EN && r.ara_done && r.cond == 5'h00 && !CONV_DONE |=> !r.alert)
    else $error("alert not released after reply");
  oneshot_busy_a: assert property ( // RULE12
    r.busy && !CONV_DONE && !r.first |=> !r.start)
    else $error("conversion restarted while busy");
  mask_out_a: assert property ( // RULE14
    r.cfg[sensor_cmd_pkg::IRQ_MASK_BIT] |-> !ALERT_OE)
    else $error("masked alert still driven");
  status_clr_a: assert property ( // RULE19
    CLK_EN && r.stat_read && r.cond == 5'h00 && !CONV_DONE
    |=> r.flags == 5'h00)
    else $error("status flags not cleared");

  ara_done_c: cover property (r.ara_done);
  stat_read_c: cover property (r.stat_read && r.alert);
  alert_c: cover property ($rose(ALERT_OE));
  start_c: cover property (r.start && r.cfg[sensor_cmd_pkg::STANDBY_BIT]);

endmodule

//--- test/smb_host_model.sv
// Host master model for the two-wire serial bus, with a rival slave
module smb_host_model (
  input wire logic clk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_oe = 1'b0;
  logic rival_oe = 1'b0;
  logic [7:0] rival = 8'hFF;

  // Pulled-up data line: any driver pulls it low
  assign sda = !(host_oe || dev_oe || rival_oe);
  // Clock stands high outside frames
  initial scl = 1'b1;

  // Wait n edges, then the common small delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start; a repeated start first raises the clock with data released
  task automatic start(input bit rep);
    if (rep) begin
      scl = 1'b0;
      tick(2);
      host_oe = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
    end
    host_oe = 1'b1;
    tick(4);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    scl = 1'b0;
    tick(2);
    host_oe = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    host_oe = 1'b0;
    tick(4);
  endtask

  // Eight bits MSB first and a ninth; all drivers change in the low phase
  task automatic xbyte(input logic [7:0] tx, input bit nack,
                       output logic [7:0] rx, output bit ack);
    for (int i = 7; i >= -1; i--) begin
      scl = 1'b0;
      tick(2);
      if (i < 0) host_oe = !nack;
      else host_oe = !tx[i];
      if (i < 0) rival_oe = 1'b0;
      else rival_oe = !rival[i];
      tick(2);
      scl = 1'b1;
      tick(4);
      if (i < 0) ack = !sda;
      else rx[i] = sda;
    end
    rival_oe = 1'b0;
  endtask
endmodule

//--- test/sensor_command_alert_logic_tb.sv
// Self-checking bench for the sensor command and alert logic
module sensor_command_alert_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FAST = 20;
  localparam int INTERVAL = FAST << 5;
  localparam logic [6:0] STRAP = 7'h4C;
  localparam logic [6:0] ARA = 7'h0C;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] strap = STRAP;
  logic conv_done = 1'b0;
  logic diode_open = 1'b0;
  logic [7:0] ltemp = 8'h19;
  logic [7:0] rtemp = 8'h15;
  logic [7:0] lfrac = 8'hA0;
  logic [7:0] rfrac = 8'h60;
  logic scl, sda, sda_oe, sda_out, alert_oe, alert_out, conv_start;
  logic ext_range, series_cancel, cpu_junction;
  logic done_d = 1'b0;
  logic done_d2 = 1'b0;
  logic alert_d = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0;
  int last_start = 0;
  int conv_cnt = 0;

  // ==========================================================
  // Clock, design and host
  initial begin
    forever #50 clk_sys = !clk_sys;
  end

  sensor_command_alert_logic #(.FAST_CYCLES(FAST)) dut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(1'b1),
    .SMB_SCL(scl), .SMB_SDA_IN(sda), .SMB_SDA_OUT(sda_out),
    .SMB_SDA_OE(sda_oe), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe),
    .ADDR_STRAP(strap), .CONV_START(conv_start), .CONV_DONE(conv_done),
    .LOCAL_TEMP_IN(ltemp), .REMOTE_TEMP_IN(rtemp),
    .LOCAL_FRAC_IN(lfrac), .REMOTE_FRAC_IN(rfrac),
    .DIODE_OPEN_IN(diode_open), .EXT_RANGE(ext_range),
    .SERIES_CANCEL(series_cancel), .CPU_JUNCTION(cpu_junction));

  smb_host_model host (.clk(clk_sys), .dev_oe(sda_oe), .scl(scl),
    .sda(sda));

  // Converter stand-in, start log, alert pacing watch and run limit
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    done_d <= conv_done;
    done_d2 <= done_d;
    alert_d <= alert_oe;
    conv_done <= #1 (conv_cnt == 1);
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      last_start <= cycles;
      conv_cnt <= 400;
    end else if (conv_cnt > 0) begin
      conv_cnt <= conv_cnt - 1;
    end
    if (alert_oe === 1'b1 && !alert_d && !done_d && !done_d2) begin
      cmp_bit("alert pacing", 1'b0, 1'b1);
    end
    if (cycles == 60000) begin
      cmp_bit("run limit", 1'b0, 1'b1);
      close_out();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Write Byte, or Send Byte when no data
  task automatic wr(input logic [7:0] cmd, d, input bit dat);
    logic [7:0] rx;
    bit a0, a1, a2;
    host.start(1'b0);
    host.xbyte({STRAP, 1'b0}, 1'b1, rx, a0);
    host.xbyte(cmd, 1'b1, rx, a1);
    a2 = 1'b1;
    if (dat) host.xbyte(d, 1'b1, rx, a2);
    host.stop();
    cmp_bit("write ack", 1'b1, a0 && a1 && a2);
  endtask

  // Read Byte with repeated start, data closed by a nack
  task automatic chk(input logic [7:0] cmd, m, exp);
    logic [7:0] d;
    bit a0, a1, a2, a3;
    host.start(1'b0);
    host.xbyte({STRAP, 1'b0}, 1'b1, d, a0);
    host.xbyte(cmd, 1'b1, d, a1);
    host.start(1'b1);
    host.xbyte({STRAP, 1'b1}, 1'b1, d, a2);
    host.xbyte(8'hFF, 1'b1, d, a3);
    host.stop();
    cmp_bit("read ack", 1'b1, a0 && a1 && a2);
    cmp($sformatf("register %h", cmd), exp, d & m);
  endtask

  // Receive Byte; rv is what a rival slave drives in the data byte
  task automatic recv(input logic [6:0] a, input logic [7:0] rv,
                      output logic [7:0] d, output bit ack);
    bit x;
    host.start(1'b0);
    host.xbyte({a, 1'b1}, 1'b1, d, ack);
    host.rival = rv;
    host.xbyte(8'hFF, 1'b1, d, x);
    host.rival = 8'hFF;
    host.stop();
  endtask

  task automatic wait_conv();
    int k = 0;
    tick(1);
    while (conv_done !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    tick(3);
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    bit a;
    logic [7:0] code [12] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h10, 8'h11, 8'hFE, 8'hFF, 8'h12, 8'h80};
    logic [7:0] want [12] = '{8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9,
      8'h60, 8'hA0, sensor_cmd_pkg::PART_ID_VAL,
      sensor_cmd_pkg::PART_REV_VAL, 8'h00, 8'h00};
    wait_conv();
    strap = 7'h11;
    recv(STRAP, 8'hFF, d, a);
    cmp("bare read", 8'h19, d);
    for (int i = 0; i < 12; i++) chk(code[i], 8'hFF, want[i]);
    $display("test reset values done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++) wr(8'(11 + i), i[0] ? 8'h05 : 8'h70, 1'b1);
    wr(8'h20, 8'h11, 1'b1);
    for (int i = 0; i < 4; i++) chk(8'(5 + i), 8'hFF, i[0] ? 8'h05 : 8'h70);
    wr(8'h09, 8'h3F, 1'b1);
    chk(8'h03, 8'hFF, 8'h38);
    cmp_bit("ext range", 1'b1, ext_range);
    cmp_bit("cpu junction", 1'b1, cpu_junction);
    cmp_bit("series cancel", 1'b1, series_cancel);
    wr(8'h0A, 8'h07, 1'b1);
    tick(2);
    cmp_bit("series cancel fast", 1'b0, series_cancel);
    wr(8'h0A, 8'h02, 1'b1);
    chk(8'h04, 8'hFF, 8'h02);
    $display("test register map done");
  endtask

  task automatic t_alert();
    ltemp = 8'h72;
    wait_conv();
    cmp_bit("alert raised", 1'b1, alert_oe);
    chk(8'h02, 8'h7F, 8'h40);
    chk(8'h02, 8'h7F, 8'h40);
    cmp_bit("alert held", 1'b1, alert_oe);
    ltemp = 8'h20;
    wait_conv();
    chk(8'h00, 8'hFF, 8'h20);
    cmp_bit("alert latched", 1'b1, alert_oe);
    chk(8'h02, 8'h7F, 8'h40);
    cmp_bit("alert released", 1'b0, alert_oe);
    chk(8'h02, 8'h7F, 8'h00);
    $display("test alert latch done");
  endtask

  task automatic t_arp();
    logic [7:0] d;
    bit a;
    diode_open = 1'b1;
    wait_conv();
    diode_open = 1'b0;
    wait_conv();
    recv(ARA, 8'h31, d, a);
    cmp("lost reply", 8'h31, d);
    cmp_bit("alert kept", 1'b1, alert_oe);
    recv(ARA, 8'hFF, d, a);
    cmp_bit("reply ack", 1'b1, a);
    cmp("reply byte", {STRAP, 1'b1}, d);
    cmp_bit("alert cleared", 1'b0, alert_oe);
    recv(ARA, 8'hFF, d, a);
    cmp_bit("idle reply", 1'b0, a);
    chk(8'h02, 8'h7F, 8'h0C);
    $display("test alert response done");
  endtask

  task automatic t_mask();
    wr(8'h09, 8'hB8, 1'b1);
    ltemp = 8'h72;
    wait_conv();
    cmp_bit("masked alert", 1'b0, alert_oe);
    ltemp = 8'h20;
    wait_conv();
    chk(8'h02, 8'h7F, 8'h40);
    wr(8'h09, 8'h38, 1'b1);
    tick(2);
    cmp_bit("unmasked idle", 1'b0, alert_oe);
    $display("test alert mask done");
  endtask

  task automatic t_oneshot();
    int n;
    wr(8'h09, 8'h78, 1'b1);
    tick(500);
    n = starts;
    wr(8'h0F, 8'h00, 1'b0);
    wr(8'h0F, 8'h00, 1'b0);
    tick(3000);
    cmp("one-shot starts", 8'h01, 8'(starts - n));
    chk(8'h02, 8'hFF, 8'h00);
    $display("test standby one-shot done");
  endtask

  task automatic t_rate();
    int t1;
    int n;
    int k = 0;
    wr(8'h09, 8'h38, 1'b1);
    wait_conv();
    wr(8'h0F, 8'h00, 1'b0);
    tick(3);
    t1 = last_start;
    n = starts;
    while (starts == n && k < 3000) begin
      tick(1);
      k++;
    end
    cmp_bit("timer restart", 1'b1, (last_start - t1) >= INTERVAL);
    $display("test autoconvert one-shot done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tick(12);
    reset_n = 1'b1;
    tick(4);
    t_reset();
    t_regs();
    t_alert();
    t_arp();
    t_mask();
    t_oneshot();
    t_rate();
    cmp_bit("alert pin level", 1'b0, alert_out);
    cmp_bit("data pin level", 1'b0, sda_out);
    close_out();
  end
endmodule
